/* File: hw/acl_entry_regs.svh */
// acl_entry_regs.svh - addresses, offsets, field positions and timing counts
// assumes: included by the port store and field block design modules, not by the acl entry package
`ifndef ACL_ENTRY_REGS_SVH
`define ACL_ENTRY_REGS_SVH

// ----------------------------------------
// host register addresses, table select and first port number
// ----------------------------------------
`define ACL_REG_IND_CTRL    8'h6E
`define ACL_REG_IND_OFFSET  8'h6F
`define ACL_REG_IND_DATA    8'hA0
`define ACL_TABLE_SEL       3'b010
`define ACL_PORT_FIRST      4'h1

// ----------------------------------------
// indirect offsets, slot indices and slot count
// ----------------------------------------
`define ACL_OFF_ACTION_A    8'h0A
`define ACL_OFF_ACTION_B    8'h0B
`define ACL_OFF_MASK_HI     8'h0C
`define ACL_OFF_MASK_LO     8'h0D
`define ACL_OFF_BSEL_HI     8'h10
`define ACL_OFF_BSEL_LO     8'h11
`define ACL_SLOT_ACTION_A   3'h0
`define ACL_SLOT_ACTION_B   3'h1
`define ACL_SLOT_MASK_HI    3'h2
`define ACL_SLOT_MASK_LO    3'h3
`define ACL_SLOT_BSEL_HI    3'h4
`define ACL_SLOT_BSEL_LO    3'h5
`define ACL_NUM_SLOTS       6

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ACL_BSEL_HI_WMASK   8'h3F
`define ACL_RESET_BYTE      8'h00
`define ACL_FWD_CNTMODE_BIT 3
`define ACL_FWD_UNIT_BIT    4
`define ACL_MATCH_COUNTER   2'b01
`define ACL_ENABLE_COUNTER  2'b00
`define ACL_MAP_LUT_ONLY    2'b00
`define ACL_MAP_OR          2'b01
`define ACL_MAP_AND         2'b10
`define ACL_MAP_MODE_MSB    6
`define ACL_MAP_MODE_LSB    5
`define ACL_VALUE_LSB       5
`define ACL_PORT_MAP_MSB    4
`define ACL_BSEL_HI_MSB     5
`define ACL_BSEL_BITS       14

// ----------------------------------------
// timing
// ----------------------------------------
`define ACL_CLK_PERIOD_NS   25
`define ACL_US_NS           1000
`define ACL_US_CYCLES       ((`ACL_US_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS)
`define ACL_MS_US           1000

`endif

/* File: hw/acl_entry_pkg.sv */
// acl_entry_pkg - types shared by the acl entry field block
// assumes: nothing beyond the register header
package acl_entry_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] slot;
   } slot_sel_t;
endpackage

/* File: hw/acl_port_store.sv */
// acl_port_store - per-port byte store for the acl entry fields
// assumes: one writer, one reader, same clock; read data registered
`timescale 1ns/1ps
`default_nettype none
`include "acl_entry_regs.svh"
module acl_port_store #(
   parameter int PORTS = 4,
   parameter int SLOTS = `ACL_NUM_SLOTS
) (
   input  wire logic                           i_clk,
   input  wire logic                           i_rstn,
   input  wire logic                           i_wr,
   input  wire logic [1:0]                     i_wr_port,
   input  wire logic [2:0]                     i_wr_slot,
   input  wire logic [7:0]                     i_wdata,
   input  wire logic                           i_rd,
   input  wire logic [1:0]                     i_rd_port,
   input  wire logic [2:0]                     i_rd_slot,
   output logic      [7:0]                     o_rdata,
   output logic      [PORTS-1:0][SLOTS-1:0][7:0] o_all
);
   logic [PORTS-1:0][SLOTS-1:0][7:0] mem_q;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int p = 0; p < PORTS; p++) begin
            for (int s = 0; s < SLOTS; s++) begin
               mem_q[p][s] <= `ACL_RESET_BYTE;
            end
         end
      end else if (i_wr) begin
         mem_q[i_wr_port][i_wr_slot] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= `ACL_RESET_BYTE;
      end else if (i_rd) begin
         o_rdata <= mem_q[i_rd_port][i_rd_slot];
      end
   end

   assign o_all = mem_q;
endmodule
`default_nettype wire

/* File: hw/acl_entry_action_and_byte_select.sv */
// acl_entry_action_and_byte_select - per-port acl port map, rule group mask,
// entry byte select and counter events behind the indirect byte window
// assumes: host strobes and per-port mode/packet inputs are on i_clk
//
// Operation
// R1 - port map bits 0,1,2,4 forward to ports 1,2,3,4; bit 3 unused
// R2 - match mode 01, enable 00: map bit 4 picks microsecond or millisecond unit
// R3 - in that mode, bit 3 clear: 11-bit countdown from action value, event on expiry
// R4 - in that mode, bit 3 set: count packets to action value, then event
// R5 - 16-bit rule group mask per port, high at 0x0C, low at 0x0D
// R6 - software selects table 010 and port, then offset, before data access
// R7 - selected field read and written through data byte at 0xA0
// R8 - 14-bit byte select mask includes or excludes entry bytes
// R9 - byte select bit 0 is entry byte 0x0D, bit 13 is byte 0x00
// R10 - select bits 13:8 at 0x10 low six bits, 7:6 zero; 7:0 at 0x11
// R11 - map mode 00 lookup only, 01 or, 10 and, 11 port map replaces
// R12 - reserved bits ignore writes; map bit 3 never forwards
`timescale 1ns/1ps
`default_nettype none
`include "acl_entry_regs.svh"
module acl_entry_action_and_byte_select
   import acl_entry_pkg::*;
#(
   parameter int PORTS     = 4,
   parameter int US_CYCLES = `ACL_US_CYCLES,
   parameter int MS_US     = `ACL_MS_US
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rstn,
   input  wire host_req_t                   i_host,
   output logic      [7:0]                  o_reg_rdata,
   input  wire logic [PORTS-1:0][1:0]       i_match_mode_field,
   input  wire logic [PORTS-1:0][1:0]       i_rule_enable_field,
   input  wire logic [PORTS-1:0]            i_pkt_rx,
   input  wire logic [PORTS-1:0][4:0]       i_lut_map,
   output logic      [PORTS-1:0][4:0]       o_fwd_map,
   output logic      [PORTS-1:0][15:0]      o_rule_group_mask,
   output logic      [PORTS-1:0][13:0]      o_entry_byte_select,
   output logic      [PORTS-1:0]            o_acl_event
);
   localparam int SLOTS = `ACL_NUM_SLOTS;

   // ----------------------------------------
   // offset decode
   // ----------------------------------------
   function automatic slot_sel_t slot_of(input logic [7:0] off);
      slot_sel_t s;
      s.valid = 1'b1;
      s.slot  = `ACL_SLOT_ACTION_A;
      case (off)
         `ACL_OFF_ACTION_A: s.slot = `ACL_SLOT_ACTION_A;
         `ACL_OFF_ACTION_B: s.slot = `ACL_SLOT_ACTION_B;
         `ACL_OFF_MASK_HI:  s.slot = `ACL_SLOT_MASK_HI;
         `ACL_OFF_MASK_LO:  s.slot = `ACL_SLOT_MASK_LO;
         `ACL_OFF_BSEL_HI:  s.slot = `ACL_SLOT_BSEL_HI;
         `ACL_OFF_BSEL_LO:  s.slot = `ACL_SLOT_BSEL_LO;
         default:           s.valid = 1'b0;
      endcase
      return s;
   endfunction

   logic [7:0]                       ind_ctrl_q;
   logic [7:0]                       ind_off_q;
   logic [7:0]                       rdata_q;
   logic                             from_store_q;
   logic [7:0]                       store_rdata;
   logic [PORTS-1:0][SLOTS-1:0][7:0] store_all;
   slot_sel_t                        sel;
   logic                             port_ok;
   logic [1:0]                       port_idx;
   logic                             data_ok;
   logic [7:0]                       wdata_m;

   // ----------------------------------------
   // indirect window
   // ----------------------------------------
   assign sel      = slot_of(ind_off_q);
   assign port_idx = 2'(ind_ctrl_q[3:0] - `ACL_PORT_FIRST);
   assign port_ok  = (ind_ctrl_q[7:5] == `ACL_TABLE_SEL) && (ind_ctrl_q[3:0] >= `ACL_PORT_FIRST)
                     && (ind_ctrl_q[3:0] < 4'(PORTS + 1));  // R6
   assign data_ok  = port_ok && sel.valid && (i_host.addr == `ACL_REG_IND_DATA);  // R7
   assign wdata_m  = (sel.slot == `ACL_SLOT_BSEL_HI) ? (i_host.wdata & `ACL_BSEL_HI_WMASK)
                                                     : i_host.wdata;  // R10 R12

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ind_ctrl_q <= `ACL_RESET_BYTE;
         ind_off_q  <= `ACL_RESET_BYTE;
      end else if (i_host.wr) begin
         if (i_host.addr == `ACL_REG_IND_CTRL) begin
            ind_ctrl_q <= i_host.wdata;
         end
         if (i_host.addr == `ACL_REG_IND_OFFSET) begin
            ind_off_q <= i_host.wdata;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_q      <= `ACL_RESET_BYTE;
         from_store_q <= 1'b0;
      end else if (i_host.rd) begin
         from_store_q <= data_ok;  // R7
         case (i_host.addr)
            `ACL_REG_IND_CTRL:   rdata_q <= ind_ctrl_q;
            `ACL_REG_IND_OFFSET: rdata_q <= ind_off_q;
            default:             rdata_q <= `ACL_RESET_BYTE;
         endcase
      end
   end

   assign o_reg_rdata = from_store_q ? store_rdata : rdata_q;

   acl_port_store #(
      .PORTS (PORTS),
      .SLOTS (SLOTS)
   ) u_store (
      .i_clk     (i_clk),
      .i_rstn    (i_rstn),
      .i_wr      (i_host.wr && data_ok),
      .i_wr_port (port_idx),
      .i_wr_slot (sel.slot),
      .i_wdata   (wdata_m),
      .i_rd      (i_host.rd && data_ok),
      .i_rd_port (port_idx),
      .i_rd_slot (sel.slot),
      .o_rdata   (store_rdata),
      .o_all     (store_all)
   );

   // ----------------------------------------
   // time base
   // ----------------------------------------
   logic [15:0] us_cnt_q;
   logic [15:0] ms_cnt_q;
   logic        us_tick;
   logic        ms_tick;

   assign us_tick = (us_cnt_q == 16'(US_CYCLES - 1));
   assign ms_tick = us_tick && (ms_cnt_q == 16'(MS_US - 1));

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         us_cnt_q <= 16'h0000;
      end else begin
         us_cnt_q <= us_tick ? 16'h0000 : 16'(us_cnt_q + 16'h0001);
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ms_cnt_q <= 16'h0000;
      end else if (us_tick) begin
         ms_cnt_q <= ms_tick ? 16'h0000 : 16'(ms_cnt_q + 16'h0001);
      end
   end

   // ----------------------------------------
   // per-port fields, forwarding and counters
   // ----------------------------------------
   for (genvar p = 0; p < PORTS; p++) begin : g_port
      logic [7:0]  act_a;
      logic [7:0]  act_b;
      logic [4:0]  pmap;
      logic [10:0] limit;
      logic        cnt_mode;
      logic        tick;
      logic [10:0] cnt_q;
      logic        armed_q;
      logic [13:0] bsel_reg;

      assign act_a    = store_all[p][`ACL_SLOT_ACTION_A];
      assign act_b    = store_all[p][`ACL_SLOT_ACTION_B];
      assign pmap     = act_b[`ACL_PORT_MAP_MSB:0] & ~(5'h01 << `ACL_FWD_CNTMODE_BIT);  // R1 R12
      assign limit    = {act_a, act_b[7:`ACL_VALUE_LSB]};  // R3 R4
      assign cnt_mode = (i_match_mode_field[p] == `ACL_MATCH_COUNTER)
                        && (i_rule_enable_field[p] == `ACL_ENABLE_COUNTER);  // R2
      assign tick     = act_b[`ACL_FWD_UNIT_BIT] ? ms_tick : us_tick;  // R2

      assign o_rule_group_mask[p] = {store_all[p][`ACL_SLOT_MASK_HI],
                                     store_all[p][`ACL_SLOT_MASK_LO]};  // R5
      assign bsel_reg = {store_all[p][`ACL_SLOT_BSEL_HI][`ACL_BSEL_HI_MSB:0],
                         store_all[p][`ACL_SLOT_BSEL_LO]};  // R10
      for (genvar b = 0; b < `ACL_BSEL_BITS; b++) begin : g_bsel
         // entry byte b is picked by the mirrored select bit
         assign o_entry_byte_select[p][b] = bsel_reg[`ACL_BSEL_BITS - 1 - b];  // R8 R9
      end

      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            o_fwd_map[p] <= 5'h00;
         end else begin
            case (act_b[`ACL_MAP_MODE_MSB:`ACL_MAP_MODE_LSB])  // R11
               `ACL_MAP_LUT_ONLY: o_fwd_map[p] <= i_lut_map[p];
               `ACL_MAP_OR:       o_fwd_map[p] <= i_lut_map[p] | pmap;
               `ACL_MAP_AND:      o_fwd_map[p] <= i_lut_map[p] & pmap;
               default:           o_fwd_map[p] <= pmap;
            endcase
         end
      end

      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            cnt_q          <= 11'h000;
            armed_q        <= 1'b0;
            o_acl_event[p] <= 1'b0;
         end else begin
            o_acl_event[p] <= 1'b0;
            if (!cnt_mode) begin
               cnt_q   <= 11'h000;
               armed_q <= 1'b0;
            end else if (!armed_q) begin
               armed_q <= 1'b1;
               cnt_q   <= act_b[`ACL_FWD_CNTMODE_BIT] ? 11'h000 : limit;
            end else if (act_b[`ACL_FWD_CNTMODE_BIT]) begin
               if (i_pkt_rx[p]) begin  // R4
                  if (11'(cnt_q + 11'h001) >= limit) begin
                     cnt_q          <= 11'h000;
                     o_acl_event[p] <= 1'b1;
                  end else begin
                     cnt_q <= 11'(cnt_q + 11'h001);
                  end
               end
            end else if (tick) begin  // R3
               if (cnt_q <= 11'h001) begin
                  cnt_q          <= limit;
                  o_acl_event[p] <= 1'b1;
               end else begin
                  cnt_q <= 11'(cnt_q - 11'h001);
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/acl_checker.sv */
// acl_checker: port-level assertions for the acl entry field block
// assumes: bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module acl_checker
   import acl_entry_pkg::*;
#(
   parameter int PORTS     = 4,
   parameter int US_CYCLES = 40,
   parameter int MS_US     = 1000
) (
   input wire logic                   i_clk,
   input wire logic                   i_rstn,
   input wire host_req_t              i_host,
   input wire logic [7:0]             o_reg_rdata,
   input wire logic [PORTS-1:0][1:0]  i_match_mode_field,
   input wire logic [PORTS-1:0][1:0]  i_rule_enable_field,
   input wire logic [PORTS-1:0][4:0]  i_lut_map,
   input wire logic [PORTS-1:0][4:0]  o_fwd_map,
   input wire logic [PORTS-1:0][15:0] o_rule_group_mask,
   input wire logic [PORTS-1:0][13:0] o_entry_byte_select,
   input wire logic [PORTS-1:0]       o_acl_event
);
   logic [7:0]       ctrl_q;
   logic [7:0]       off_q;
   logic [PORTS-1:0] cm;
   logic [PORTS-1:0] b3;
   logic [PORTS-1:0] l3;
   logic             sel_ok;
   logic             dat;
   logic             mapped;
   // shadow of the window select, to know when data access is legal
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q <= 8'h00;
         off_q  <= 8'h00;
      end else if (i_host.wr) begin
         if (i_host.addr == 8'h6E) ctrl_q <= i_host.wdata;
         if (i_host.addr == 8'h6F) off_q <= i_host.wdata;
      end
   end
   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         cm[p] = i_match_mode_field[p] == 2'b01 && i_rule_enable_field[p] == 2'b00;
         b3[p] = o_fwd_map[p][3];
         l3[p] = i_lut_map[p][3];
      end
   end
   assign sel_ok = ctrl_q[7:5] == 3'b010 && ctrl_q[3:0] >= 4'h1 && ctrl_q[3:0] <= 4'h4;
   assign dat    = i_host.addr == 8'hA0;
   assign mapped = dat || i_host.addr == 8'h6E || i_host.addr == 8'h6F;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_hold; !i_host.rd |=> $stable(o_reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_unmap; i_host.rd && !mapped |=> o_reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_refrd; i_host.rd && dat && !sel_ok |=> o_reg_rdata == 8'h00; endproperty
   a_refrd: assert property (p_refrd) else $error("refused read not zero");
   property p_refwr; i_host.wr && dat && !sel_ok |=> $stable(o_rule_group_mask) && $stable(o_entry_byte_select);
   endproperty
   a_refwr: assert property (p_refwr) else $error("refused write changed a field");
   property p_mask; $changed(o_rule_group_mask) |-> $past(i_host.wr) && $past(i_host.addr) == 8'hA0; endproperty
   a_mask: assert property (p_mask) else $error("mask changed without data write");
   property p_bsel; $changed(o_entry_byte_select) |-> $past(i_host.wr) && $past(i_host.addr) == 8'hA0; endproperty
   a_bsel: assert property (p_bsel) else $error("byte select changed without data write");
   property p_hi; i_host.rd && dat && sel_ok && off_q == 8'h10 |=> o_reg_rdata[7:6] == 2'b00; endproperty
   a_hi: assert property (p_hi) else $error("reserved select bits read nonzero");
   property p_b3; o_fwd_map != '0 |-> (b3 & ~$past(l3)) == '0; endproperty
   a_b3: assert property (p_b3) else $error("port map bit 3 forwarded");
   property p_evt; o_acl_event != '0 |-> (o_acl_event & ~($past(cm) | $past(cm, 2))) == '0; endproperty
   a_evt: assert property (p_evt) else $error("event outside counter mode");
endmodule
bind acl_entry_action_and_byte_select acl_checker #(.PORTS(PORTS), .US_CYCLES(US_CYCLES), .MS_US(MS_US)) chk (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_host(i_host), .o_reg_rdata(o_reg_rdata),
   .i_match_mode_field(i_match_mode_field), .i_rule_enable_field(i_rule_enable_field),
   .i_lut_map(i_lut_map), .o_fwd_map(o_fwd_map), .o_rule_group_mask(o_rule_group_mask),
   .o_entry_byte_select(o_entry_byte_select), .o_acl_event(o_acl_event));
`default_nettype wire

/* File: testbench/testbench.sv */
// testbench: drives the acl entry field block through its byte window
// assumes: design package compiled first, short counter parameters
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import acl_entry_pkg::*;
   logic             i_clk;
   logic             i_rstn;
   host_req_t        i_host;
   logic [7:0]       rdata;
   logic [3:0][1:0]  md;
   logic [3:0][1:0]  en;
   logic [3:0]       pkt;
   logic [3:0]       evt;
   logic [3:0][4:0]  lut;
   logic [3:0][4:0]  fwd;
   logic [3:0][15:0] msk;
   logic [3:0][13:0] bsel;
   int               n_errors;
   int               compares;
   // rows: port, offset, written byte, byte read back
   logic [27:0]      rows [8] = '{{4'h1, 8'h0C, 8'hA5, 8'hA5}, {4'h1, 8'h0D, 8'h3C, 8'h3C},
      {4'h2, 8'h10, 8'hFF, 8'h3F}, {4'h2, 8'h11, 8'h81, 8'h81}, {4'h3, 8'h0D, 8'h80, 8'h80},
      {4'h3, 8'h11, 8'h7E, 8'h7E}, {4'h4, 8'h0C, 8'h01, 8'h01}, {4'h4, 8'h10, 8'hC1, 8'h01}};
   logic [4:0]       fexp [4] = '{5'h16, 5'h17, 5'h04, 5'h05};
   acl_entry_action_and_byte_select #(.PORTS(4), .US_CYCLES(2), .MS_US(3)) uut (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_host(i_host), .o_reg_rdata(rdata),
      .i_match_mode_field(md), .i_rule_enable_field(en), .i_pkt_rx(pkt), .i_lut_map(lut),
      .o_fwd_map(fwd), .o_rule_group_mask(msk), .o_entry_byte_select(bsel), .o_acl_event(evt));
   // ---
   // tasks
   // ---
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_host <= {1'b1, 1'b0, a, d};
      @(posedge i_clk);
      i_host <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_host <= {1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk);
      i_host <= '0;
      #1 d = rdata;
   endtask
   task automatic sel(input logic [3:0] p, input logic [7:0] o);
      wr(8'h6E, {4'h4, p});
      wr(8'h6F, o);
   endtask
   task automatic gap(output int n);
      int k;
      k = 0;
      n = 0;
      while (evt[0] !== 1'b1 && k < 100) begin
         @(posedge i_clk);
         #1 k++;
      end
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (evt[0] !== 1'b1 && n < 100);
      @(posedge i_clk);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   function automatic logic [13:0] rev14(input logic [13:0] v);
      for (int b = 0; b < 14; b++) rev14[b] = v[13-b];
   endfunction
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   initial begin
      #500000;
      n_errors++;
      stop_test;
   end
   // ---
   // stimulus
   // ---
   initial begin
      logic [7:0] d;
      int         n;
      n_errors = 0;
      compares = 0;
      i_rstn = 1'b0;
      i_host = '0;
      md = '0;
      en = '0;
      pkt = '0;
      lut = {5'h11, 5'h04, 5'h02, 5'h16};
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk("fwd", 16'(lut[0]), 16'(fwd[0]));
      chk("mask", 16'h0000, msk[1]);
      chk("bsel", 16'h0000, 16'(bsel[2]));
      sel(4'h2, 8'h10);
      rd(8'hA0, d);
      chk("rdata", 16'h0000, 16'(d));
      $display("test reset done");
      foreach (rows[i]) begin
         sel(rows[i][27:24], rows[i][23:16]);
         wr(8'hA0, rows[i][15:8]);
         rd(8'hA0, d);
         chk("rdata", 16'(rows[i][7:0]), 16'(d));
      end
      chk("mask", 16'hA53C, msk[0]);
      chk("mask", 16'h0080, msk[2]);
      chk("mask", 16'h0100, msk[3]);
      chk("bsel", 16'h207F, 16'(bsel[1]));
      chk("bsel", 16'(rev14(14'h007E)), 16'(bsel[2]));
      chk("bsel", 16'(rev14(14'h0100)), 16'(bsel[3]));
      $display("test table done");
      wr(8'h6E, 8'h61);
      wr(8'hA0, 8'hFF);
      rd(8'hA0, d);
      chk("rdata", 16'h0000, 16'(d));
      chk("mask", 16'hA53C, msk[0]);
      wr(8'h6E, 8'h40);
      rd(8'hA0, d);
      chk("rdata", 16'h0000, 16'(d));
      rd(8'h55, d);
      chk("rdata", 16'h0000, 16'(d));
      $display("test refused done");
      sel(4'h1, 8'h0B);
      rd(8'h6F, d);
      chk("rdata", 16'h000B, 16'(d));
      for (int m = 0; m < 4; m++) begin
         wr(8'hA0, {1'b0, 2'(m), 5'h0D});
         repeat (2) @(posedge i_clk);
         chk("fwd", 16'(fexp[m]), 16'(fwd[0]));
      end
      $display("test forward done");
      wr(8'hA0, 8'h40);
      md[0] <= 2'b01;
      gap(n);
      chk("us gap", 16'd4, 16'(n));
      md[0] <= 2'b00;
      wr(8'hA0, 8'h50);
      md[0] <= 2'b01;
      gap(n);
      chk("ms gap", 16'd12, 16'(n));
      md[0] <= 2'b00;
      wr(8'hA0, 8'h68);
      md[0] <= 2'b01;
      repeat (2) @(posedge i_clk);
      for (int k = 0; k < 3; k++) begin
         @(posedge i_clk);
         pkt[0] <= 1'b1;
         @(posedge i_clk);
         pkt[0] <= 1'b0;
         #1 chk("pkt event", 16'(k == 2), 16'(evt[0]));
      end
      @(posedge i_clk);
      en[0] <= 2'b01;
      for (int k = 0; k < 3; k++) begin
         @(posedge i_clk);
         pkt[0] <= 1'b1;
         @(posedge i_clk);
         pkt[0] <= 1'b0;
         #1 chk("pkt event", 16'h0000, 16'(evt[0]));
      end
      $display("test counter done");
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1 chk("mask", 16'h0000, msk[0]);
      chk("bsel", 16'h0000, 16'(bsel[1]));
      chk("fwd", 16'(lut[0]), 16'(fwd[0]));
      $display("test reset again done");
      stop_test;
   end
endmodule
`default_nettype wire
